// File: logic/srq_status_report.sv
// status reporting and service request block of the remote interface
`timescale 1ns/1ps
`default_nettype none
module srq_status_report (
    input  wire logic              mclk,
    input  wire logic              rst,
    input  wire logic              power_on_clear,
    input  wire srq_pkg::srq_cmd_t cmd,
    input  wire logic              clear_status,
    input  wire logic              scan_idle,
    input  wire logic              command_idle,
    input  wire logic              out_avail,
    input  wire logic              ev_in_ovf,
    input  wire logic              ev_out_ovf,
    input  wire logic              ev_exec_err,
    input  wire logic              ev_illegal_cmd,
    input  wire logic              ev_user,
    input  wire logic [7:0]        measure_cond_events,
    input  wire logic [7:0]        fault_events,
    input  wire logic              poll_req,
    output srq_pkg::srq_resp_t     resp,
    output logic                   poll_valid,
    output logic [7:0]             poll_byte,
    output logic                   service_req
);
    typedef struct packed {
        srq_pkg::srq_resp_t resp;
        logic               poll_valid;
        logic [7:0]         poll_byte;
        logic               service_req;
        logic [7:0]         poll_live;
        logic               pon_done;
    } srq_top_state_t;

    srq_top_state_t state_reg;
    srq_top_state_t state_next;

    logic [7:0] ev_status;
    logic [7:0] ev_enable;
    logic       ev_sum;
    logic [7:0] ms_status;
    logic [7:0] ms_enable;
    logic       ms_sum;
    logic [7:0] ft_status;
    logic [7:0] ft_enable;
    logic       ft_sum;
    logic [7:0] pe_enable;
    logic       req_pending;

    logic [7:0] ev_set;
    logic [7:0] ev_clr;
    logic [7:0] ms_clr;
    logic [7:0] ft_clr;
    logic [7:0] bit_mask;
    logic [7:0] bit_write;
    logic       is_write;
    logic       is_read;
    logic [7:0] cond_byte;
    logic [7:0] query_byte;
    logic [7:0] sel_byte;
    logic [7:0] pe_wr_val;
    logic [7:0] ev_wr_val;
    logic [7:0] ms_wr_val;
    logic [7:0] ft_wr_val;

    // decode of the command port
    always_comb
    begin
        is_write  = cmd.valid && !cmd.is_query;
        is_read   = cmd.valid && cmd.is_query;
        bit_mask  = 8'h01 << cmd.bit_idx;
        bit_write = cmd.value[0] ? bit_mask : 8'h00;
    end

    // write value for an enable register: whole byte or one bit
    function automatic logic [7:0] srq_en_value(
        input logic [7:0] cur,
        input logic       single,
        input logic [7:0] mask,
        input logic [7:0] bitv,
        input logic [7:0] whole
    );
        srq_en_value = single ? ((cur & ~mask) | bitv) : whole;
    endfunction

    assign ev_wr_val = srq_en_value(ev_enable, cmd.single_bit, bit_mask, bit_write, cmd.value);
    assign ms_wr_val = srq_en_value(ms_enable, cmd.single_bit, bit_mask, bit_write, cmd.value);
    assign ft_wr_val = srq_en_value(ft_enable, cmd.single_bit, bit_mask, bit_write, cmd.value);
    assign pe_wr_val = srq_en_value(pe_enable, cmd.single_bit, bit_mask, bit_write, cmd.value);

    // read-to-clear masks; poll status is never cleared by a query
    function automatic logic [7:0] srq_rd_clear(
        input logic       hit,
        input logic       single,
        input logic [7:0] mask
    );
        srq_rd_clear = !hit ? 8'h00 : (single ? mask : 8'hff);
    endfunction

    always_comb
    begin
        ev_clr = srq_rd_clear(is_read && cmd.sel == srq_pkg::SRQ_SEL_EVENT_ST,
                              cmd.single_bit, bit_mask);
        ms_clr = srq_rd_clear(is_read && cmd.sel == srq_pkg::SRQ_SEL_MEAS_ST,
                              cmd.single_bit, bit_mask);
        ft_clr = srq_rd_clear(is_read && cmd.sel == srq_pkg::SRQ_SEL_FAULT_ST,
                              cmd.single_bit, bit_mask);
        if (clear_status)
        begin
            ev_clr = 8'hff;
            ms_clr = 8'hff;
            ft_clr = 8'hff;
        end
    end

    // standard event byte layout; power-on event raised once after reset
    always_comb
    begin
        ev_set = 8'h00;
        ev_set[srq_pkg::EV_IN_OVF_BIT]      = ev_in_ovf;
        ev_set[srq_pkg::EV_OUT_OVF_BIT]     = ev_out_ovf;
        ev_set[srq_pkg::EV_EXEC_ERR_BIT]    = ev_exec_err;
        ev_set[srq_pkg::EV_ILLEGAL_CMD_BIT] = ev_illegal_cmd;
        ev_set[srq_pkg::EV_USER_BIT]        = ev_user;
        ev_set[srq_pkg::EV_POWER_ON_BIT]    = !state_reg.pon_done;
    end

    srq_status_byte #(
        .USED_MASK (srq_pkg::EVENT_USED_MASK)
    ) u_event (
        .mclk        (mclk),
        .rst         (rst),
        .keep_enable (!power_on_clear),
        .event_set   (ev_set),
        .status_clr  (ev_clr),
        .en_write    (is_write && cmd.sel == srq_pkg::SRQ_SEL_EVENT_EN),
        .en_value    (ev_wr_val),
        .status      (ev_status),
        .enable      (ev_enable),
        .summary     (ev_sum)
    );

    srq_status_byte #(
        .USED_MASK (srq_pkg::MEAS_USED_MASK)
    ) u_measure (
        .mclk        (mclk),
        .rst         (rst),
        .keep_enable (!power_on_clear),
        .event_set   (measure_cond_events),
        .status_clr  (ms_clr),
        .en_write    (is_write && cmd.sel == srq_pkg::SRQ_SEL_MEAS_EN),
        .en_value    (ms_wr_val),
        .status      (ms_status),
        .enable      (ms_enable),
        .summary     (ms_sum)
    );

    srq_status_byte #(
        .USED_MASK (srq_pkg::FAULT_USED_MASK)
    ) u_fault (
        .mclk        (mclk),
        .rst         (rst),
        .keep_enable (!power_on_clear),
        .event_set   (fault_events),
        .status_clr  (ft_clr),
        .en_write    (is_write && cmd.sel == srq_pkg::SRQ_SEL_FAULT_EN),
        .en_value    (ft_wr_val),
        .status      (ft_status),
        .enable      (ft_enable),
        .summary     (ft_sum)
    );

    // poll enable reuses the byte cell; its status half is unused
    srq_status_byte #(
        .USED_MASK (8'h00)
    ) u_poll_en (
        .mclk        (mclk),
        .rst         (rst),
        .keep_enable (!power_on_clear),
        .event_set   (8'h00),
        .status_clr  (8'h00),
        .en_write    (is_write && cmd.sel == srq_pkg::SRQ_SEL_POLL_EN),
        .en_value    (pe_wr_val),
        .status      (),
        .enable      (pe_enable),
        .summary     ()
    );

    // live conditions of the poll byte, bits 0-5
    always_comb
    begin
        cond_byte = 8'h00;
        cond_byte[srq_pkg::SP_SCAN_IDLE_BIT] = scan_idle;
        cond_byte[srq_pkg::SP_CMD_IDLE_BIT]  = command_idle;
        cond_byte[srq_pkg::SP_FAULT_SUM_BIT] = ft_sum;
        cond_byte[srq_pkg::SP_MEAS_SUM_BIT]  = ms_sum;
        cond_byte[srq_pkg::SP_OUT_AVAIL_BIT] = out_avail;
        cond_byte[srq_pkg::SP_EVENT_SUM_BIT] = ev_sum;
    end

    // request edge is taken from the registered poll byte so it aligns with queries
    srq_edge_request u_req (
        .mclk     (mclk),
        .rst      (rst),
        .masked   (state_reg.poll_live & pe_enable),
        .poll_ack (poll_req),
        .pending  (req_pending)
    );

    // query view of bit 6: any enabled bit set, bit 7 zero
    always_comb
    begin
        query_byte = state_reg.poll_live;
        query_byte[srq_pkg::SP_REQUEST_BIT] = |(state_reg.poll_live & pe_enable);
    end

    always_comb
    begin
        case (cmd.sel)
            srq_pkg::SRQ_SEL_EVENT_EN: sel_byte = ev_enable;
            srq_pkg::SRQ_SEL_EVENT_ST: sel_byte = ev_status;
            srq_pkg::SRQ_SEL_POLL_EN:  sel_byte = pe_enable;
            srq_pkg::SRQ_SEL_POLL_ST:  sel_byte = query_byte;
            srq_pkg::SRQ_SEL_FAULT_EN: sel_byte = ft_enable;
            srq_pkg::SRQ_SEL_FAULT_ST: sel_byte = ft_status;
            srq_pkg::SRQ_SEL_MEAS_EN:  sel_byte = ms_enable;
            srq_pkg::SRQ_SEL_MEAS_ST:  sel_byte = ms_status;
            default:                   sel_byte = 8'h00;
        endcase
    end

    always_comb
    begin
        state_next = state_reg;
        state_next.pon_done   = 1'b1;
        state_next.poll_live  = cond_byte;
        state_next.resp.valid = is_read;
        state_next.poll_valid = poll_req;
        if (is_read)
        begin
            // whole byte or a single bit as 0/1
            state_next.resp.value = cmd.single_bit ? {7'h00, sel_byte[cmd.bit_idx]} : sel_byte;
        end
        if (poll_req)
        begin
            // poll returns the pending flag in bit 6, other bits untouched
            state_next.poll_byte = state_reg.poll_live;
            state_next.poll_byte[srq_pkg::SP_REQUEST_BIT] = req_pending;
        end
        state_next.service_req = req_pending && !poll_req;
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            state_reg <= '0;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    assign resp        = state_reg.resp;
    assign poll_valid  = state_reg.poll_valid;
    assign poll_byte   = state_reg.poll_byte;
    assign service_req = state_reg.service_req;
endmodule
`default_nettype wire

// File: logic/srq_pkg.sv
// shared constants and carrier types of the status reporting block
package srq_pkg;
    localparam int unsigned BYTE_W = 8;

    // serial poll status bit positions
    localparam int unsigned SP_SCAN_IDLE_BIT    = 0;
    localparam int unsigned SP_CMD_IDLE_BIT     = 1;
    localparam int unsigned SP_FAULT_SUM_BIT    = 2;
    localparam int unsigned SP_MEAS_SUM_BIT     = 3;
    localparam int unsigned SP_OUT_AVAIL_BIT    = 4;
    localparam int unsigned SP_EVENT_SUM_BIT    = 5;
    localparam int unsigned SP_REQUEST_BIT      = 6;

    // standard event bit positions
    localparam int unsigned EV_IN_OVF_BIT       = 0;
    localparam int unsigned EV_OUT_OVF_BIT      = 2;
    localparam int unsigned EV_EXEC_ERR_BIT     = 4;
    localparam int unsigned EV_ILLEGAL_CMD_BIT  = 5;
    localparam int unsigned EV_USER_BIT         = 6;
    localparam int unsigned EV_POWER_ON_BIT     = 7;

    // bits that may ever be set in each status byte, then the status and enable reset values
    localparam logic [7:0] EVENT_USED_MASK = 8'hf5;
    localparam logic [7:0] MEAS_USED_MASK  = 8'h7f;
    localparam logic [7:0] FAULT_USED_MASK = 8'hf6;
    localparam logic [7:0] STATUS_RESET    = 8'h00;
    localparam logic [7:0] ENABLE_RESET    = 8'h00;

    // register selector used by command and query ports
    typedef enum logic [2:0] {
        SRQ_SEL_EVENT_EN,
        SRQ_SEL_EVENT_ST,
        SRQ_SEL_POLL_EN,
        SRQ_SEL_POLL_ST,
        SRQ_SEL_FAULT_EN,
        SRQ_SEL_FAULT_ST,
        SRQ_SEL_MEAS_EN,
        SRQ_SEL_MEAS_ST
    } srq_sel_t;

    // one command or query from the interface parser
    typedef struct packed {
        logic       valid;
        logic       is_query;
        srq_sel_t   sel;
        logic       single_bit;
        logic [2:0] bit_idx;
        logic [7:0] value;
    } srq_cmd_t;

    // answer to a query
    typedef struct packed {
        logic       valid;
        logic [7:0] value;
    } srq_resp_t;
endpackage

// File: logic/srq_status_byte.sv
// one sticky status byte with its enable register and summary bit
`timescale 1ns/1ps
`default_nettype none
module srq_status_byte #(
    parameter logic [7:0] USED_MASK = 8'hff
) (
    input  wire logic       mclk,
    input  wire logic       rst,
    input  wire logic       keep_enable,
    input  wire logic [7:0] event_set,
    input  wire logic [7:0] status_clr,
    input  wire logic       en_write,
    input  wire logic [7:0] en_value,
    output logic      [7:0] status,
    output logic      [7:0] enable,
    output logic            summary
);
    typedef struct packed {
        logic [7:0] status;
        logic [7:0] enable;
        logic       primed;
    } srq_byte_state_t;

    srq_byte_state_t state_reg;
    srq_byte_state_t state_next;

    always_comb
    begin
        state_next = state_reg;
        // set wins over a clearing read in the same cycle
        state_next.status = ((state_reg.status & ~status_clr) | event_set) & USED_MASK;
        if (en_write)
        begin
            state_next.enable = en_value;
        end
        // first cycle after power-up: apply the power-on-clear setting
        if (!state_reg.primed)
        begin
            state_next.primed = 1'b1;
            if (!keep_enable)
            begin
                state_next.enable = srq_pkg::ENABLE_RESET;
            end
        end
    end

    // enables take no reset and hold through it, so they can survive a power cycle
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            state_reg.status <= srq_pkg::STATUS_RESET;
            state_reg.primed <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    assign status  = state_reg.status;
    assign enable  = state_reg.enable;
    assign summary = |(state_reg.status & state_reg.enable);
endmodule
`default_nettype wire

// File: logic/srq_edge_request.sv
// rising-edge service request latch with serial poll acknowledge
`timescale 1ns/1ps
`default_nettype none
module srq_edge_request (
    input  wire logic       mclk,
    input  wire logic       rst,
    input  wire logic [7:0] masked,
    input  wire logic       poll_ack,
    output logic            pending
);
    typedef struct packed {
        logic [7:0] prev;
        logic       pending;
    } srq_edge_state_t;

    srq_edge_state_t state_reg;
    srq_edge_state_t state_next;

    always_comb
    begin
        state_next = state_reg;
        state_next.prev = masked;
        if (poll_ack)
        begin
            state_next.pending = 1'b0;
        end
        // a new rising enabled bit wins over a simultaneous poll
        if (|(masked & ~state_reg.prev))
        begin
            state_next.pending = 1'b1;
        end
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            state_reg <= '0;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    assign pending = state_reg.pending;
endmodule
`default_nettype wire

// File: verification/srq_status_report_chk.sv
// port assertions of the status reporting block
`timescale 1ns/1ps
`default_nettype none
module srq_status_report_chk (
    input wire logic               mclk,
    input wire logic               rst,
    input wire srq_pkg::srq_cmd_t  cmd,
    input wire logic               scan_idle,
    input wire logic               command_idle,
    input wire logic               out_avail,
    input wire logic               poll_req,
    input wire srq_pkg::srq_resp_t resp,
    input wire logic               poll_valid,
    input wire logic [7:0]         poll_byte
);
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);

    logic qry;
    assign qry = cmd.valid && cmd.is_query;

    a_query_answered : assert property (
        qry |=> resp.valid) else $error("query left unanswered");
    a_answer_caused : assert property (
        resp.valid |-> $past(qry)) else $error("answer without a query");
    a_answer_held : assert property (
        !qry |=> $stable(resp.value)) else $error("answer value moved without a query");
    a_poll_answered : assert property (
        poll_req |=> poll_valid && !poll_byte[7]) else $error("poll answer missing or bit 7 set");
    a_poll_byte_held : assert property (
        !poll_req |=> $stable(poll_byte)) else $error("poll byte moved without a poll");
    // live bits reach the poll byte through two register stages
    a_poll_live_bits : assert property (
        poll_valid && !$past(rst, 2) |-> poll_byte[0] == $past(scan_idle, 2)
            && poll_byte[1] == $past(command_idle, 2) && poll_byte[4] == $past(out_avail, 2))
        else $error("poll byte live bits wrong");
    a_bit_answer_narrow : assert property (
        qry && cmd.single_bit |=> resp.value[7:1] == 7'h00) else $error("bit query wider than one bit");
    a_cond_top_zero : assert property (
        qry && !cmd.single_bit && cmd.sel == srq_pkg::SRQ_SEL_MEAS_ST |=> !resp.value[7])
        else $error("unused condition bit set");
    a_event_gaps_zero : assert property (
        qry && !cmd.single_bit && cmd.sel == srq_pkg::SRQ_SEL_EVENT_ST
            |=> resp.value[3] == 1'b0 && resp.value[1] == 1'b0)
        else $error("unused event bit set");
endmodule

bind srq_status_report srq_status_report_chk u_chk (
    .mclk(mclk), .rst(rst), .cmd(cmd), .scan_idle(scan_idle),
    .command_idle(command_idle), .out_avail(out_avail), .poll_req(poll_req),
    .resp(resp), .poll_valid(poll_valid), .poll_byte(poll_byte)
);
`default_nettype wire

// File: verification/srq_ctrl_model.sv
// behavioural remote controller that answers service requests with serial polls
`timescale 1ns/1ps
`default_nettype none
module srq_ctrl_model (
    input  wire logic       mclk,
    input  wire logic       service_req,
    input  wire logic       auto_poll,
    input  wire logic       poll_now,
    input  wire logic [3:0] poll_delay,
    input  wire logic       poll_valid,
    input  wire logic [7:0] poll_byte,
    output logic            poll_req,
    output logic      [7:0] polled,
    output int              n_polls
);
    initial
    begin
        poll_req = 1'b0;
        polled   = 8'h00;
        n_polls  = 0;
    end

    always @(posedge mclk)
    begin
        if (poll_now || (auto_poll && service_req))
        begin
            repeat (poll_delay) @(posedge mclk);
            #1 poll_req = 1'b1;
            @(posedge mclk);
            #1 poll_req = 1'b0;
            // bit 6 of a poll means request pending, not enabled-bit-set
            polled = poll_valid ? poll_byte : 8'hxx;
            n_polls++;
            // the request output drops on the same edge as the poll; wait 3 cycles before checking it again
            repeat (3) @(posedge mclk);
        end
    end
endmodule
`default_nettype wire

// File: verification/srq_status_report_tb.sv
// self-checking bench of the status reporting block
`timescale 1ns/1ps
`default_nettype none
module srq_status_report_tb;
    logic               mclk = 1'b0;
    logic               rst = 1'b1;
    logic               power_on_clear = 1'b1;
    srq_pkg::srq_cmd_t  cmd = '0;
    logic               clear_status = 1'b0;
    logic [2:0]         live = 3'h0;
    logic [4:0]         ev_in = 5'h00;
    logic [7:0]         meas_in = 8'h00;
    logic [7:0]         fault_in = 8'h00;
    logic               auto_poll = 1'b0;
    logic               poll_now = 1'b0;
    logic [3:0]         poll_delay = 4'h0;
    logic               poll_req;
    srq_pkg::srq_resp_t resp;
    logic               poll_valid;
    logic [7:0]         poll_byte;
    logic               service_req;
    logic [7:0]         polled;
    int                 n_polls;
    logic [7:0]         st [4];
    logic [7:0]         en [4];
    int                 ss [3] = '{1, 5, 7};
    int                 n_mismatch = 0;
    int                 comparisons = 0;
    int                 k;
    logic [2:0]         b;

    always #2.5 mclk = ~mclk;

    srq_status_report dut (
        .mclk(mclk), .rst(rst), .power_on_clear(power_on_clear), .cmd(cmd),
        .clear_status(clear_status), .scan_idle(live[0]), .command_idle(live[1]),
        .out_avail(live[2]), .ev_in_ovf(ev_in[0]), .ev_out_ovf(ev_in[1]),
        .ev_exec_err(ev_in[2]), .ev_illegal_cmd(ev_in[3]), .ev_user(ev_in[4]),
        .measure_cond_events(meas_in), .fault_events(fault_in), .poll_req(poll_req),
        .resp(resp), .poll_valid(poll_valid), .poll_byte(poll_byte),
        .service_req(service_req)
    );

    srq_ctrl_model ctrl (
        .mclk(mclk), .service_req(service_req), .auto_poll(auto_poll),
        .poll_now(poll_now), .poll_delay(poll_delay), .poll_valid(poll_valid),
        .poll_byte(poll_byte), .poll_req(poll_req), .polled(polled), .n_polls(n_polls)
    );

    function automatic logic [7:0] ev_byte(logic [4:0] e);
        return {1'b0, e[4], e[3], e[2], 1'b0, e[1], 1'b0, e[0]};
    endfunction

    function automatic logic [7:0] poll_exp();
        logic [7:0] p;
        p = {2'b00, |(st[0] & en[0]), live[2], |(st[3] & en[3]), |(st[2] & en[2]), live[1:0]};
        p[6] = |(p[5:0] & en[1][5:0]);
        return p;
    endfunction

    task automatic check8(logic [7:0] got, logic [7:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic test_done();
        $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
        if (n_mismatch == 0 && comparisons > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic send(logic q, int s, logic sb, logic [2:0] i, logic [7:0] val);
        @(posedge mclk);
        #1 cmd = {1'b1, q, srq_pkg::srq_sel_t'(s), sb, i, val};
        @(posedge mclk);
        #1 cmd.valid = 1'b0;
    endtask

    // compare the answer, then apply the clear-on-read side effect
    task automatic query(int s, logic sb, logic [2:0] i);
        logic [7:0] cur;
        cur = (s == 3) ? poll_exp() : ((s % 2 == 1) ? st[s / 2] : en[s / 2]);
        send(1'b1, s, sb, i, 8'h00);
        check8({7'h00, resp.valid}, 8'h01);
        check8(resp.value, sb ? {7'h00, cur[i]} : cur);
        if (s % 2 == 1 && s != 3)
        begin
            if (sb)
                st[s / 2][i] = 1'b0;
            else
                st[s / 2] = 8'h00;
        end
    endtask

    task automatic wr_en(int n, logic sb, logic [2:0] i, logic [7:0] val);
        send(1'b0, 2 * n, sb, i, val);
        if (sb)
            en[n][i] = val[0];
        else
            en[n] = val;
    endtask

    task automatic fire(logic [4:0] e, logic [7:0] m, logic [7:0] f);
        @(posedge mclk);
        #1 {ev_in, meas_in, fault_in} = {e, m, f};
        @(posedge mclk);
        #1 {ev_in, meas_in, fault_in} = '0;
        st[0] |= ev_byte(e);
        st[3] |= m & srq_pkg::MEAS_USED_MASK;
        st[2] |= f & srq_pkg::FAULT_USED_MASK;
        repeat (4) @(posedge mclk);
        // look at registered outputs only once they have settled
        #1;
    endtask

    task automatic do_reset(logic poc);
        power_on_clear = poc;
        rst = 1'b1;
        repeat (20) @(posedge mclk);
        #1 rst = 1'b0;
        if (poc)
            en = '{default: 8'h00};
        st = '{8'h80, 8'h00, 8'h00, 8'h00};
        @(posedge mclk);
    endtask

    task automatic wait_polls(int c);
        int n;
        for (n = 0; n < 60 && n_polls == c; n++)
            @(posedge mclk);
        #1;
        check8(8'(n_polls - c), 8'h01);
        if (n_polls == c)
            test_done();
    endtask

    task automatic poll();
        int c;
        c = n_polls;
        repeat (4) @(posedge mclk);
        #1 poll_now = 1'b1;
        @(posedge mclk);
        #1 poll_now = 1'b0;
        wait_polls(c);
    endtask

    task automatic wait_srq();
        int n;
        for (n = 0; n < 12 && service_req !== 1'b1; n++)
            @(posedge mclk);
        #1;
        check8({7'h00, service_req}, 8'h01);
        if (service_req !== 1'b1)
            test_done();
    endtask

    initial
    begin
        k = $urandom(32'hb02e9d4b);
        do_reset(1'b1);
        for (k = 0; k < 8; k++)
            query(k, 1'b0, 3'h0);
        query(1, 1'b0, 3'h0);
        for (k = 0; k < 12; k++)
        begin
            b = 3'($urandom);
            wr_en(k % 4, 1'b0, 3'h0, 8'($urandom));
            query(2 * (k % 4), 1'b0, 3'h0);
            wr_en(k % 4, 1'b1, b, 8'($urandom));
            query(2 * (k % 4), 1'b1, b);
            query(2 * (k % 4), 1'b0, 3'h0);
            live = 3'($urandom);
            fire(5'($urandom), 8'($urandom), 8'($urandom));
            query(3, 1'b0, 3'h0);
            query(3, 1'b1, b);
            query(ss[k % 3], 1'b1, b);
            query(ss[(k + 1) % 3], 1'b0, 3'h0);
            query(3, 1'b0, 3'h0);
        end
        live = 3'h0;
        fire(5'h1f, 8'hff, 8'hff);
        @(posedge mclk);
        #1 clear_status = 1'b1;
        @(posedge mclk);
        #1 clear_status = 1'b0;
        st = '{default: 8'h00};
        for (k = 0; k < 8; k++)
            query(k, 1'b0, 3'h0);
        wr_en(1, 1'b0, 3'h0, 8'h04);
        wr_en(2, 1'b0, 3'h0, 8'hff);
        // a request may be left over from the random phase
        poll();
        poll_delay = 4'h5;
        auto_poll = 1'b1;
        k = n_polls;
        fire(5'h00, 8'h00, 8'h02);
        wait_polls(k);
        auto_poll = 1'b0;
        poll_delay = 4'h0;
        check8(polled, 8'h44);
        check8({7'h00, service_req}, 8'h00);
        poll();
        check8(polled, 8'h04);
        fire(5'h00, 8'h00, 8'h04);
        check8({7'h00, service_req}, 8'h00);
        query(3, 1'b0, 3'h0);
        query(5, 1'b1, 3'h1);
        query(3, 1'b0, 3'h0);
        query(5, 1'b0, 3'h0);
        query(3, 1'b0, 3'h0);
        fire(5'h00, 8'h00, 8'h10);
        wait_srq();
        @(posedge mclk);
        #1 cmd = {1'b1, 1'b1, srq_pkg::SRQ_SEL_FAULT_ST, 1'b0, 3'h0, 8'h00};
        fault_in = 8'h20;
        @(posedge mclk);
        #1 cmd.valid = 1'b0;
        fault_in = 8'h00;
        check8(resp.value, st[2]);
        st[2] = 8'h20;
        query(5, 1'b0, 3'h0);
        wr_en(0, 1'b0, 3'h0, 8'h80);
        wr_en(1, 1'b0, 3'h0, 8'h20);
        do_reset(1'b0);
        query(0, 1'b0, 3'h0);
        query(2, 1'b0, 3'h0);
        wait_srq();
        test_done();
    end
endmodule
`default_nettype wire
